// file: design/fxr_ext_read_reg.v
`timescale 1ns/1ps
`include "fxr_defs.vh"

module fxr_ext_read_reg (
  // System
  input  wire       clk,
  input  wire       nrst,
  // Serial link, sampled
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       si,
  input  wire       qpi_mode,
  output reg        so,
  output reg        so_oe,
  // Read decode towards the read engine
  output reg  [3:0] dummy_cycles,
  output reg        read_refused,
  output reg  [7:0] last_opcode,
  // Drive control
  output reg  [2:0] drive_strength,
  output reg        learning_pattern_enable,
  // Array controller status
  input  wire       op_done,
  input  wire [3:0] op_kind,
  input  wire       op_fail,
  input  wire       op_erase_fail,
  input  wire       op_protected,
  input  wire       op_asp_only,
  input  wire       sw_reset,
  // Non-volatile copy and volatile register
  output reg  [7:0] nv_copy,
  output reg  [7:0] ext_read_reg
);

  localparam ST_CMD  = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_OUT  = 2'h2;
  localparam ST_IDLE = 2'h3;

  // Dummy count per opcode; a zero with refusal marks unsupported modes.
  function [4:0] dummy_of;
    input [7:0] op;
    input       qpi;
    begin
      case (op)
        `FXR_CMD_FREAD,
        `FXR_CMD_FREAD4,
        `FXR_CMD_FDTR,
        `FXR_CMD_FDTR4,
        `FXR_CMD_UID,
        `FXR_CMD_INFO_ROW_READ_CMD:
          dummy_of = {1'b0, qpi ? `FXR_DUMMY_6 : `FXR_DUMMY_8};
        `FXR_CMD_DOUT,
        `FXR_CMD_DOUT4,
        `FXR_CMD_QOUT,
        `FXR_CMD_QOUT4:
          dummy_of = qpi ? {1'b1, `FXR_DUMMY_NONE} : {1'b0, `FXR_DUMMY_8};
        `FXR_CMD_DIO,
        `FXR_CMD_DIO4,
        `FXR_CMD_DIODTR,
        `FXR_CMD_DIODTR4:
          dummy_of = qpi ? {1'b1, `FXR_DUMMY_NONE} : {1'b0, `FXR_DUMMY_4};
        `FXR_CMD_QIO,
        `FXR_CMD_QIO4,
        `FXR_CMD_QIODTR,
        `FXR_CMD_QIODTR4:
          dummy_of = {1'b0, `FXR_DUMMY_6};
        // Opcodes outside the read set report no dummies and are never refused.
        default:
          dummy_of = {1'b0, `FXR_DUMMY_NONE};
      endcase
    end
  endfunction

  // Two-flop synchronisers for the pins.
  reg  [1:0] sclk_s_q;
  reg  [1:0] cs_s_q;
  reg  [1:0] si_s_q;
  reg  [1:0] qpi_s_q;
  reg        sclk_prev_q;
  // Frame tracking.
  reg  [1:0] st_q;
  reg  [2:0] bit_q;
  reg  [7:0] sh_q;
  reg  [7:0] op_q;
  // Register bank state.
  reg        nv_loaded_q;
  reg  [2:0] set_err;

  localparam [7:0] RESET_VAL = `FXR_RESET_VAL;
  localparam [7:0] RW_MASK   = `FXR_RW_MASK;

  wire       rise       = sclk_s_q[1] & ~sclk_prev_q;
  wire       fall       = ~sclk_s_q[1] & sclk_prev_q;
  wire       csel       = ~cs_s_q[1];
  wire [7:0] rx_byte    = {sh_q[6:0], si_s_q[1]};
  wire       byte_end   = csel & rise & (bit_q == 3'h7);
  wire       cmd_end    = byte_end & (st_q == ST_CMD);
  wire       data_end   = byte_end & (st_q == ST_DATA);
  wire       set_v_end  = data_end & (op_q == `FXR_CMD_SET_V);
  wire       set_nv_end = data_end & (op_q == `FXR_CMD_SET_NV);
  wire       clear_cmd  = cmd_end & (rx_byte == `FXR_CMD_CLEAR_ERR);

  // Only the writable upper bits of a set-parameters byte are kept.
  function [7:0] merge_rw;
    input [7:0] old_val;
    input [7:0] new_val;
    begin
      merge_rw = (new_val & RW_MASK) | (old_val & ~RW_MASK);
    end
  endfunction

  // Error flag sources: bit order {erase, program, protection}.
  always @* begin
    set_err = 3'h0;
    if (op_done) begin
      case (op_kind)
        // Lock-bit and unlock failures count as program failures.
        `FXR_OP_PROGRAM,
        `FXR_OP_INFO_PROG,
        `FXR_OP_MODE_LOCK,
        `FXR_OP_UNLOCK:
          set_err = {1'b0, op_fail | op_protected, op_protected};
        `FXR_OP_NV_REG:
          set_err = {op_erase_fail, op_fail, 1'b0};
        // A locked status write counts as an erase-side failure as well.
        `FXR_OP_STATUS_WR:
          set_err = {op_erase_fail | op_protected, op_fail, op_protected};
        `FXR_OP_FUNC_WR:
          set_err = {1'b0, op_fail, 1'b0};
        `FXR_OP_ERASE:
          set_err = {op_fail | op_protected, 1'b0, op_protected};
        // Per-sector protection alone does not flag a chip erase.
        `FXR_OP_CHIP_ERASE:
          set_err = {op_fail | (op_protected & ~op_asp_only), 1'b0,
                     op_protected & ~op_asp_only};
        default:
          set_err = 3'h0;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      sclk_s_q <= 2'h0;
      cs_s_q   <= 2'h3;
      si_s_q   <= 2'h0;
      qpi_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk};
      cs_s_q   <= {cs_s_q[0], cs_n};
      si_s_q   <= {si_s_q[0], si};
      qpi_s_q  <= {qpi_s_q[0], qpi_mode};
    end
  end

  // Edge history reads only the second synchroniser stage, never the first.
  always @(posedge clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  // Frame tracking: the opcode byte decides whether data, register output or nothing follows.
  always @(posedge clk) begin
    if (!nrst) begin
      st_q  <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      op_q  <= 8'h00;
    end else if (!csel) begin
      st_q  <= ST_CMD;
      bit_q <= 3'h0;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= rx_byte;
      case (st_q)
        ST_CMD: begin
          if (bit_q == 3'h7) begin
            op_q <= rx_byte;
            // The register byte is captured here so a read sees one consistent snapshot.
            sh_q <= ext_read_reg;
            if (rx_byte == `FXR_CMD_READ_REG) begin
              st_q <= ST_OUT;
            end else if (rx_byte == `FXR_CMD_SET_NV || rx_byte == `FXR_CMD_SET_V) begin
              st_q <= ST_DATA;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_DATA: begin
          if (bit_q == 3'h7) begin
            st_q <= ST_IDLE;
          end
        end
        ST_OUT: begin
          st_q <= ST_OUT;
        end
        ST_IDLE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Decode results stand until the next opcode, so the read engine may take them late.
  always @(posedge clk) begin
    if (!nrst) begin
      dummy_cycles <= 4'h0;
      read_refused <= 1'b0;
      last_opcode  <= 8'h00;
    end else if (cmd_end) begin
      // A refused read reports zero dummies so the engine never waits on it.
      {read_refused, dummy_cycles} <= dummy_of(rx_byte, qpi_s_q[1]);
      last_opcode                  <= rx_byte;
    end
  end

  // The byte leaves on falling link edges, giving the host half a period of setup.
  always @(posedge clk) begin
    if (!nrst) begin
      so    <= 1'b0;
      so_oe <= 1'b0;
    end else if (!csel) begin
      // The data line keeps its last bit while released; only the enable tells.
      so_oe <= 1'b0;
    end else if (fall && st_q == ST_OUT) begin
      so    <= sh_q[7];
      so_oe <= 1'b1;
    end
  end

  // A reset returns the stored copy to its default; real cells would keep it.
  always @(posedge clk) begin
    if (!nrst) begin
      nv_copy <= RESET_VAL;
    end else if (set_nv_end) begin
      // Flag bits in the byte are dropped, the stored flags are never written.
      nv_copy <= merge_rw(nv_copy, rx_byte);
    end
  end

  // Volatile copy follows the stored copy once after reset, flags clear.
  always @(posedge clk) begin
    if (!nrst) begin
      ext_read_reg <= RESET_VAL;
      nv_loaded_q  <= 1'b0;
    end else if (!nv_loaded_q) begin
      nv_loaded_q  <= 1'b1;
      ext_read_reg <= nv_copy & RW_MASK;
    end else begin
      if (set_v_end) begin
        ext_read_reg[7:4] <= rx_byte[7:4];
      end
      // Hardware events win over a clear in the same cycle; commands still run.
      if (clear_cmd) begin
        ext_read_reg[3:1] <= set_err;
      end else begin
        ext_read_reg[3:1] <= (sw_reset ? 3'h0 : ext_read_reg[3:1]) | set_err;
      end
    end
  end

  // Drive controls lag the register by one clock, so the pads only see settled codes.
  always @(posedge clk) begin
    if (!nrst) begin
      drive_strength          <= RESET_VAL[`FXR_DS_MSB:`FXR_DS_LSB];
      learning_pattern_enable <= RESET_VAL[`FXR_LPE_BIT];
    end else begin
      drive_strength          <= ext_read_reg[`FXR_DS_MSB:`FXR_DS_LSB];
      learning_pattern_enable <= ext_read_reg[`FXR_LPE_BIT];
    end
  end

endmodule

// file: include/fxr_defs.vh
`ifndef FXR_DEFS_VH
`define FXR_DEFS_VH

// Extended read register layout.
`define FXR_DS_MSB          7
`define FXR_DS_LSB          5
`define FXR_LPE_BIT         4
`define FXR_EERR_BIT        3
`define FXR_PERR_BIT        2
`define FXR_PROT_BIT        1
`define FXR_RESET_VAL       8'hE0
`define FXR_RW_MASK         8'hF0

// Drive strength codes.
`define FXR_DS_RSVD0        3'h0
`define FXR_DS_RSVD4        3'h4

// Opcodes.
`define FXR_CMD_SET_NV      8'h85
`define FXR_CMD_SET_V       8'h83
`define FXR_CMD_READ_REG    8'h81
`define FXR_CMD_CLEAR_ERR   8'h82
`define FXR_CMD_FREAD       8'h0B
`define FXR_CMD_FREAD4      8'h0C
`define FXR_CMD_FDTR        8'h0D
`define FXR_CMD_FDTR4       8'h0E
`define FXR_CMD_UID         8'h4B
`define FXR_CMD_INFO_ROW_READ_CMD        8'h68
`define FXR_CMD_DOUT        8'h3B
`define FXR_CMD_DOUT4       8'h3C
`define FXR_CMD_QOUT        8'h6B
`define FXR_CMD_QOUT4       8'h6C
`define FXR_CMD_DIO         8'hBB
`define FXR_CMD_DIO4        8'hBC
`define FXR_CMD_DIODTR      8'hBD
`define FXR_CMD_DIODTR4     8'hBE
`define FXR_CMD_QIO         8'hEB
`define FXR_CMD_QIO4        8'hEC
`define FXR_CMD_QIODTR      8'hED
`define FXR_CMD_QIODTR4     8'hEE

// Default dummy cycle counts.
`define FXR_DUMMY_8         4'h8
`define FXR_DUMMY_6         4'h6
`define FXR_DUMMY_4         4'h4
`define FXR_DUMMY_NONE      4'h0

// Operation kinds reported by the array controller.
`define FXR_OP_NONE         4'h0
`define FXR_OP_PROGRAM      4'h1
`define FXR_OP_INFO_PROG    4'h2
`define FXR_OP_MODE_LOCK    4'h3
`define FXR_OP_UNLOCK       4'h4
`define FXR_OP_NV_REG       4'h5
`define FXR_OP_STATUS_WR    4'h6
`define FXR_OP_FUNC_WR      4'h7
`define FXR_OP_ERASE        4'h8
`define FXR_OP_CHIP_ERASE   4'h9

`endif

// file: verification/fxr_assertions.sv
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_assertions (
  // System
  input wire       clk,
  input wire       nrst,
  input wire       sw_reset,
  // Array controller status
  input wire       op_done,
  input wire [3:0] op_kind,
  input wire       op_fail,
  input wire       op_erase_fail,
  input wire       op_protected,
  // Register and read decode
  input wire [3:0] dummy_cycles,
  input wire       read_refused,
  input wire [7:0] ext_read_reg
);
  wire [2:0] fl = ext_read_reg[3:1];
  wire       ev = op_done && !sw_reset;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  rst_value_a: assert property (disable iff (1'b0) !nrst |=> ext_read_reg == 8'hE0) else $error("bad reset value");
  no_rise_a: assert property (!$past(op_done) |-> (fl & ~$past(fl)) == 3'h0) else $error("flag rose unprompted");
  prog_fail_a: assert property (ev && op_kind == `FXR_OP_PROGRAM && op_fail |=> fl[1]) else $error("program error lost");
  prog_prot_a: assert property (ev && op_kind == `FXR_OP_PROGRAM && op_protected |=> fl[1:0] == 2'h3) else $error("protected program");
  stat_lock_a: assert property (ev && op_kind == `FXR_OP_STATUS_WR && op_protected |=> fl[2] && fl[0]) else $error("locked status");
  erase_prot_a: assert property (ev && op_kind == `FXR_OP_ERASE && op_protected |=> fl[2] && fl[0]) else $error("protected erase");
  nv_erase_a: assert property (ev && op_kind == `FXR_OP_NV_REG && op_erase_fail |=> fl[2]) else $error("nv erase phase");
  sw_clear_a: assert property (sw_reset && !op_done |=> fl == 3'h0) else $error("soft reset kept flags");
  refuse_zero_a: assert property (read_refused |-> dummy_cycles == 4'h0) else $error("refused read has dummies");
  refuse_c: cover property (read_refused);
  erase_c: cover property (fl == 3'h5);
  prot_c: cover property (fl == 3'h3);
endmodule

bind fxr_ext_read_reg fxr_assertions fxr_assertions_inst (.clk(clk), .nrst(nrst), .sw_reset(sw_reset), .op_done(op_done),
  .op_kind(op_kind), .op_fail(op_fail), .op_erase_fail(op_erase_fail), .op_protected(op_protected),
  .dummy_cycles(dummy_cycles), .read_refused(read_refused), .ext_read_reg(ext_read_reg));

// file: verification/fxr_host_model.sv
`timescale 1ns/1ps
module fxr_host_model (
  // Clock and returned data
  input  wire  clk,
  input  wire  so,
  // Link pins
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic si = 1'b0
);
  // Mode 0 frame, 8 clk per bit; the link clock stands still low between frames.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = so;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // The data line has no pull, so once released it shows the inverse of its last bit.
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: verification/fxr_ext_read_reg_tb_top.sv
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_ext_read_reg_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        qpi_mode = 1'b0;
  logic        op_done = 1'b0;
  logic [3:0]  op_kind = 4'h0;
  logic        op_fail = 1'b0;
  logic        op_erase_fail = 1'b0;
  logic        op_protected = 1'b0;
  logic        op_asp_only = 1'b0;
  logic        sw_reset = 1'b0;
  logic [15:0] rx;
  wire         sclk, cs_n, si, so, so_oe, lpe, read_refused;
  wire  [3:0]  dummy_cycles;
  wire  [2:0]  drive_strength;
  wire  [7:0]  last_opcode, nv_copy, ext_read_reg;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [7:0]  rd_ops [18] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
                             8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hEB, 8'hEC, 8'hED, 8'hEE};
  // Entry: kind, fail, erase fail, protected, protection by sector bits only, expected {erase, program, protect}.
  logic [10:0] fl_tab [13] = '{11'h0C2, 11'h093, 11'h113, 11'h193, 11'h213, 11'h2C2, 11'h2A4,
                             11'h315, 11'h3C2, 11'h444, 11'h415, 11'h495, 11'h498};
  always #50 clk = ~clk;
  fxr_host_model fxr_host_model_inst (.clk(clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
  fxr_ext_read_reg fxr_ext_read_reg_inst (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .qpi_mode(qpi_mode), .so(so), .so_oe(so_oe), .dummy_cycles(dummy_cycles), .read_refused(read_refused),
    .last_opcode(last_opcode), .drive_strength(drive_strength), .learning_pattern_enable(lpe),
    .op_done(op_done), .op_kind(op_kind), .op_fail(op_fail), .op_erase_fail(op_erase_fail),
    .op_protected(op_protected), .op_asp_only(op_asp_only), .sw_reset(sw_reset), .nv_copy(nv_copy),
    .ext_read_reg(ext_read_reg));
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task rd_reg(input logic [7:0] exp);
    fxr_host_model_inst.xfer(16'h8100, 16, rx);
    chk("reg_read", rx[7:0], exp);
    chk("so_oe_idle", {7'h0, so_oe}, 8'h00);
  endtask
  task t_dummy;
    for (int q = 0; q < 2; q++) begin
      for (int i = 0; i < 18; i++) begin
        qpi_mode <= q[0];
        fxr_host_model_inst.xfer({8'h00, rd_ops[i]}, 8, rx);
        chk("dummy", {4'h0, dummy_cycles}, (q == 0) ? ((i < 10) ? 8'h08 : (i < 14) ? 8'h04 : 8'h06)
          : ((i > 5 && i < 14) ? 8'h00 : 8'h06));
        chk("refused", {7'h0, read_refused}, {7'h0, q == 1 && i > 5 && i < 14});
        chk("opcode", last_opcode, rd_ops[i]);
      end
    end
    qpi_mode <= 1'b0;
  endtask
  task t_drive;
    for (int c = 1; c < 8; c++) begin
      if (c != 4) begin
        fxr_host_model_inst.xfer({8'h83, c[2:0], 5'h1F}, 16, rx);
        chk("drive", {5'h0, drive_strength}, {5'h0, c[2:0]});
      end
    end
    rd_reg(8'hF0);
    chk("lpe", {7'h0, lpe}, 8'h01);
    fxr_host_model_inst.xfer(16'h852F, 16, rx);
    chk("nv_write", {nv_copy[7:4], ext_read_reg[7:4]}, 8'h2F);
  endtask
  task op_pulse(input logic [10:0] e);
    @(posedge clk) sw_reset <= 1'b1;
    @(posedge clk) sw_reset <= 1'b0;
    {op_kind, op_fail, op_erase_fail, op_protected, op_asp_only} <= e[10:3];
    op_done <= 1'b1;
    @(posedge clk) op_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task t_flags;
    for (int i = 0; i < 13; i++) begin
      op_pulse(fl_tab[i]);
      chk("flags", {5'h0, ext_read_reg[3:1]},
        {5'h0, fl_tab[i][2:0]});
    end
  endtask
  task t_sticky;
    op_pulse(fl_tab[10]);
    fxr_host_model_inst.xfer(16'h83FF, 16, rx);
    rd_reg(8'hFA);
    fxr_host_model_inst.xfer(16'h0082, 8, rx);
    rd_reg(8'hF0);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rereset", ext_read_reg, 8'hE0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("drive_rst", {5'h0, drive_strength}, 8'h07);
    rd_reg(8'hE0);
    t_dummy;
    t_drive;
    t_flags;
    t_sticky;
    report_and_stop;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
endmodule
